// ### pkg/scsr_params.svh
// constants of the status register group block: offsets, selects, reset values
// assumes inclusion from the package, the core and the top testbench
//
// Notes on behaviour
// RULE1 - every status group has five 16-bit registers, one bit per status everywhere
// RULE2 - bit 15 of every register always reads zero
// RULE3 - controller writes only values 0 to 32767, no symbolic values
// RULE4 - binary, hex, octal or decimal notation arrive here as one binary word
// RULE5 - current state follows hardware inputs or lower group summary; here only the pins feed it
// RULE6 - current state is read-only; writes and reads leave it alone
// RULE7 - rising current bit sets event bit when rise filter bit set
// RULE8 - falling current bit sets event bit when fall filter bit set
// RULE9 - rise and fall filters are read/write; reads keep contents
// RULE10 - event bits are sticky, set only by filtered transitions
// RULE11 - event register is read-only and a read clears it
// RULE12 - group summary is OR of event bits ANDed with mask bits
// RULE13 - summary mask is read/write at any time; reads keep contents
// RULE14 - each group summary feeds a current-state bit of the next group; here each feeds a status byte bit instead
// RULE15 - status byte with request enable sits on top, fed by four summaries
// RULE16 - request enable masks status byte; event enable masks standard events
// RULE17 - single parallel poll flag, bits chosen by poll enable register
// RULE18 - message-available bit shows output queue holds a message
// RULE19 - access per subregister; event and current query-only, others read/write
// RULE20 - operation group bit 4 carries measurement in progress
// RULE21 - enable bit 6 ignored; request raised when enabled byte bit rises
// RULE22 - poll flag is OR of byte bits ANDed with poll enable, bit 6 too
// RULE23 - an event set in the cycle of a clearing read survives
// RULE24 - reset clears events and loads fixed filter and mask defaults
`ifndef SCSR_PARAMS_SVH
`define SCSR_PARAMS_SVH
`define SCSR_GRP_OPER 2'h0
`define SCSR_GRP_QUES 2'h1
`define SCSR_GRP_DEV 2'h2
`define SCSR_GRP_IEEE 2'h3
`define SCSR_SUB_EVENT 3'h0
`define SCSR_SUB_COND 3'h1
`define SCSR_SUB_RISE 3'h2
`define SCSR_SUB_FALL 3'h3
`define SCSR_SUB_MASK 3'h4
`define SCSR_SUB_ESR 3'h0
`define SCSR_SUB_ESE 3'h1
`define SCSR_SUB_STB 3'h2
`define SCSR_SUB_SRE 3'h3
`define SCSR_SUB_PPE 3'h4
`define SCSR_RISE_RST 15'h7fff
`define SCSR_FALL_RST 15'h0000
`define SCSR_MASK_RST 15'h0000
`define SCSR_BYTE_RST 8'h00
`define SCSR_BIT_DEV 1
`define SCSR_BIT_EAV 2
`define SCSR_BIT_QUES 3
`define SCSR_BIT_MAV 4
`define SCSR_BIT_ESB 5
`define SCSR_BIT_MSS 6
`define SCSR_BIT_OPER 7
`define SCSR_BIT_MEAS 4
`define SCSR_SRE_USED 8'hbf
`endif

// ### pkg/scsr_pkg.sv
// types of the status register group block
// assumes scsr_params.svh sits beside it
`include "scsr_params.svh"
package scsr_pkg;
  typedef struct packed {
    logic [14:0] s1;
    logic [14:0] s2;
    logic [14:0] cond;
    logic [14:0] rise;
    logic [14:0] fall;
    logic [14:0] ev;
    logic [14:0] mask;
  } scsr_grp_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [1:0]  grp;
    logic [2:0]  sub;
    logic [15:0] wdata;
  } scsr_acc_t;

  typedef struct packed {
    scsr_grp_t [2:0] grp;
    logic [7:0]      esr;
    logic [7:0]      ese;
    logic [7:0]      sre;
    logic [7:0]      ppe;
    logic [7:0]      stb;
    logic [15:0]     rdata;
    logic            ack;
    logic            err;
    logic            srq;
    logic            ist;
  } scsr_state_t;
endpackage : scsr_pkg

// ### core/scsr_top.sv
// status register groups, standard event register and status byte
// assumes status pins are asynchronous; access port, queues, events on clk
`timescale 1ns/10ps
`default_nettype none
`include "scsr_params.svh"
module scsr_top (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [14:0]       oper_cond_in,
  input  wire logic [14:0]       ques_cond_in,
  input  wire logic [14:0]       dev_cond_in,
  input  wire logic [7:0]        std_event_in,
  input  wire logic              mav_in,
  input  wire logic              eav_in,
  input  wire scsr_pkg::scsr_acc_t acc,
  output logic [15:0]            acc_rdata_r,
  output logic                   acc_ack_r,
  output logic                   acc_err_r,
  output logic [7:0]             stb_r,
  output logic                   srq_pulse_r,
  output logic                   ist_r
);
  import scsr_pkg::*;

  // ----------------------------------------
  // state and combinational summaries
  // ----------------------------------------
  scsr_state_t s_r;
  scsr_state_t s_nxt;
  logic [14:0] cin [3];
  logic [2:0]  sum;
  logic [7:0]  stb_c;
  logic [7:0]  req_bits;
  logic        new_req;

  assign cin[0] = oper_cond_in; // bit 4 is measurement in progress [RULE20]
  assign cin[1] = ques_cond_in;
  assign cin[2] = dev_cond_in;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sum
      assign sum[gi] = |(s_r.grp[gi].ev & s_r.grp[gi].mask); // [RULE12]
    end
  endgenerate

  always_comb begin
    stb_c                   = 8'h00;
    stb_c[`SCSR_BIT_DEV]    = sum[`SCSR_GRP_DEV]; // [RULE14] [RULE15]
    stb_c[`SCSR_BIT_EAV]    = eav_in;
    stb_c[`SCSR_BIT_QUES]   = sum[`SCSR_GRP_QUES];
    stb_c[`SCSR_BIT_MAV]    = mav_in; // [RULE18]
    stb_c[`SCSR_BIT_ESB]    = |(s_r.esr & s_r.ese); // [RULE16]
    stb_c[`SCSR_BIT_OPER]   = sum[`SCSR_GRP_OPER];
    // master summary never looks at itself
    stb_c[`SCSR_BIT_MSS]    = |(stb_c & s_r.sre & `SCSR_SRE_USED); // [RULE16]
    req_bits                = stb_c & s_r.sre & `SCSR_SRE_USED; // [RULE21]
    new_req                 = |(req_bits & ~s_r.stb);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [14:0] wval;
    logic [14:0] rise_ev;
    logic [14:0] fall_ev;
    logic        wr_bad;
    wval    = acc.wdata[14:0];
    rise_ev = 15'h0000;
    fall_ev = 15'h0000;
    // a value above 32767 is refused whole rather than truncated [RULE3]
    wr_bad  = acc.wdata[15];
    s_nxt       = s_r;
    s_nxt.ack   = 1'b0;
    s_nxt.err   = 1'b0;
    s_nxt.rdata = 16'h0000;
    s_nxt.srq   = new_req; // [RULE21]
    s_nxt.ist   = |(stb_c & s_r.ppe); // bit 6 included [RULE17] [RULE22]
    s_nxt.stb   = stb_c;
    for (int g = 0; g < 3; g++) begin
      s_nxt.grp[g].s1   = cin[g];
      s_nxt.grp[g].s2   = s_r.grp[g].s1;
      s_nxt.grp[g].cond = s_r.grp[g].s2; // [RULE5]
    end
    if (acc.req) begin
      s_nxt.ack = 1'b1;
      // notation is decoded upstream; the word arrives binary [RULE4]
      if (acc.grp != `SCSR_GRP_IEEE) begin
        unique case (acc.sub) // [RULE19]
          `SCSR_SUB_EVENT: begin
            s_nxt.rdata = {1'b0, s_r.grp[acc.grp].ev}; // [RULE2]
            if (acc.wr) s_nxt.err = 1'b1;
            else s_nxt.grp[acc.grp].ev = 15'h0000; // [RULE11]
          end
          `SCSR_SUB_COND: begin
            s_nxt.rdata = {1'b0, s_r.grp[acc.grp].cond}; // [RULE6]
            s_nxt.err   = acc.wr;
          end
          `SCSR_SUB_RISE: begin
            s_nxt.rdata = {1'b0, s_r.grp[acc.grp].rise}; // [RULE9]
            if (acc.wr && !wr_bad) s_nxt.grp[acc.grp].rise = wval;
            s_nxt.err = acc.wr && wr_bad;
          end
          `SCSR_SUB_FALL: begin
            s_nxt.rdata = {1'b0, s_r.grp[acc.grp].fall}; // [RULE9]
            if (acc.wr && !wr_bad) s_nxt.grp[acc.grp].fall = wval;
            s_nxt.err = acc.wr && wr_bad;
          end
          `SCSR_SUB_MASK: begin
            s_nxt.rdata = {1'b0, s_r.grp[acc.grp].mask}; // [RULE13]
            if (acc.wr && !wr_bad) s_nxt.grp[acc.grp].mask = wval;
            s_nxt.err = acc.wr && wr_bad;
          end
          default: s_nxt.err = 1'b1;
        endcase
      end else begin
        unique case (acc.sub)
          `SCSR_SUB_ESR: begin
            s_nxt.rdata = {8'h00, s_r.esr};
            if (acc.wr) s_nxt.err = 1'b1;
            else s_nxt.esr = 8'h00;
          end
          `SCSR_SUB_ESE: begin
            s_nxt.rdata = {8'h00, s_r.ese};
            if (acc.wr && !wr_bad) s_nxt.ese = acc.wdata[7:0];
            s_nxt.err = acc.wr && wr_bad;
          end
          `SCSR_SUB_STB: begin
            s_nxt.rdata = {8'h00, stb_c};
            s_nxt.err   = acc.wr;
          end
          `SCSR_SUB_SRE: begin
            s_nxt.rdata = {8'h00, s_r.sre};
            if (acc.wr && !wr_bad) s_nxt.sre = acc.wdata[7:0];
            s_nxt.err = acc.wr && wr_bad;
          end
          `SCSR_SUB_PPE: begin
            s_nxt.rdata = {8'h00, s_r.ppe};
            if (acc.wr && !wr_bad) s_nxt.ppe = acc.wdata[7:0];
            s_nxt.err = acc.wr && wr_bad;
          end
          default: s_nxt.err = 1'b1;
        endcase
      end
    end
    // sets are applied after the clear so a coincident event survives [RULE23]
    for (int g = 0; g < 3; g++) begin
      rise_ev = s_r.grp[g].s2 & ~s_r.grp[g].cond & s_r.grp[g].rise; // [RULE7]
      fall_ev = ~s_r.grp[g].s2 & s_r.grp[g].cond & s_r.grp[g].fall; // [RULE8]
      s_nxt.grp[g].ev = s_nxt.grp[g].ev | rise_ev | fall_ev; // [RULE10] [RULE1]
    end
    s_nxt.esr = s_nxt.esr | std_event_in; // [RULE23]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int g = 0; g < 3; g++) begin
        s_r.grp[g].s1   <= 15'h0000;
        s_r.grp[g].s2   <= 15'h0000;
        s_r.grp[g].cond <= 15'h0000;
        s_r.grp[g].rise <= `SCSR_RISE_RST; // [RULE24]
        s_r.grp[g].fall <= `SCSR_FALL_RST;
        s_r.grp[g].ev   <= 15'h0000;
        s_r.grp[g].mask <= `SCSR_MASK_RST;
      end
      s_r.esr   <= 8'h00;
      s_r.ese   <= `SCSR_BYTE_RST;
      s_r.sre   <= `SCSR_BYTE_RST;
      s_r.ppe   <= `SCSR_BYTE_RST;
      s_r.stb   <= 8'h00;
      s_r.rdata <= 16'h0000;
      s_r.ack   <= 1'b0;
      s_r.err   <= 1'b0;
      s_r.srq   <= 1'b0;
      s_r.ist   <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign acc_rdata_r = s_r.rdata;
  assign acc_ack_r   = s_r.ack;
  assign acc_err_r   = s_r.err;
  assign stb_r       = s_r.stb;
  assign srq_pulse_r = s_r.srq;
  assign ist_r       = s_r.ist;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [14:0] set0;
  assign set0 = (s_r.grp[0].s2 & ~s_r.grp[0].cond & s_r.grp[0].rise)
              | (~s_r.grp[0].s2 & s_r.grp[0].cond & s_r.grp[0].fall);

  chk_cond_follow: assert property ( // [RULE5]
    ##3 s_r.grp[0].cond == $past(oper_cond_in, 3))
    else $error("current state does not follow its pins");

  chk_cond_ro: assert property ( // [RULE6]
    acc.req && acc.wr && acc.grp == `SCSR_GRP_QUES && acc.sub == `SCSR_SUB_COND
    |=> acc_err_r && acc_ack_r ##2 s_r.grp[1].cond == $past(ques_cond_in, 3))
    else $error("write to current state not refused");

  chk_event_set: assert property ( // [RULE7]
    set0 != 15'h0000 |=> (s_r.grp[0].ev & $past(set0)) == $past(set0))
    else $error("filtered transition lost");

  chk_event_hold: assert property ( // [RULE10]
    !acc.req |=> (s_r.grp[0].ev & $past(s_r.grp[0].ev)) == $past(s_r.grp[0].ev))
    else $error("event bit dropped without a read");

  chk_read_clear: assert property ( // [RULE11]
    acc.req && !acc.wr && acc.grp == `SCSR_GRP_OPER && acc.sub == `SCSR_SUB_EVENT
    |=> s_r.grp[0].ev == $past(set0) && acc_rdata_r == {1'b0, $past(s_r.grp[0].ev)})
    else $error("event read did not clear or lost a set");

  chk_msb_zero: assert property ( // [RULE2]
    acc_ack_r |-> !acc_rdata_r[15])
    else $error("bit 15 read as one");

  chk_oper_sum: assert property ( // [RULE12]
    (s_r.grp[0].ev[`SCSR_BIT_MEAS] && s_r.grp[0].mask[`SCSR_BIT_MEAS]) |=> stb_r[`SCSR_BIT_OPER])
    else $error("operation summary missing in status byte");

  chk_mav_bit: assert property ( // [RULE18]
    ##1 stb_r[`SCSR_BIT_MAV] == $past(mav_in))
    else $error("message bit wrong");

  chk_srq_rise: assert property ( // [RULE21]
    s_r.sre[`SCSR_BIT_OPER] && sum[`SCSR_GRP_OPER] && !stb_r[`SCSR_BIT_OPER]
    |=> srq_pulse_r ##1 !srq_pulse_r || stb_r != $past(stb_r))
    else $error("service request not raised on rise");

  chk_ist_poll: assert property ( // [RULE22]
    mav_in && s_r.ppe[`SCSR_BIT_MAV] |=> ist_r)
    else $error("poll flag not set");
endmodule : scsr_top
`default_nettype wire

// ### tb/scsr_ctl_model.sv
// controller model: issues status register accesses and returns the answers
// assumes the access port answers one edge after it takes a request
`timescale 1ns/10ps
`default_nettype none
module scsr_ctl_model (
  input  wire logic                clk,
  output var  scsr_pkg::scsr_acc_t acc,
  input  wire logic [15:0]         acc_rdata_r,
  input  wire logic                acc_ack_r,
  input  wire logic                acc_err_r
);
  import scsr_pkg::*;
  initial acc = '0;
  // ---------------------------------------------------------------
  // one access
  // ---------------------------------------------------------------
  // idle lines show the inverse of the last request, so stale values never look valid
  task automatic xfer(input logic wr, input logic [1:0] grp, input logic [2:0] sub,
                      input logic [15:0] wd, output logic [15:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk) #1;
    acc <= '{req: 1'b1, wr: wr, grp: grp, sub: sub, wdata: {1'b0, wd[14:0]}};
    @(posedge clk) #1;
    acc <= {1'b0, ~acc[21:0]};
    while (acc_ack_r !== 1'b1 && n < 4) begin
      @(posedge clk) #1;
      n++;
    end
    rd = acc_rdata_r;
    er = (acc_ack_r === 1'b1) ? acc_err_r : 1'bx;
  endtask : xfer
endmodule : scsr_ctl_model
`default_nettype wire

// ### tb/tb_top.sv
// top testbench: status pins, register groups, status byte and poll flag
// assumes the controller model drives the access port
`timescale 1ns/10ps
`default_nettype none
`include "scsr_params.svh"
module tb_top;
  import scsr_pkg::*;
  logic        clk, sys_rst, mav_in, eav_in, srq_pulse_r, ist_r;
  logic        acc_ack_r, acc_err_r, er;
  logic [14:0] oper_cond_in, ques_cond_in, dev_cond_in;
  logic [7:0]  std_event_in, stb_r;
  logic [15:0] acc_rdata_r, rd;
  scsr_acc_t   acc;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          n_srq = 0;
  int          srq_base = 0;

  scsr_top i_scsr_top (.clk(clk), .sys_rst(sys_rst), .oper_cond_in(oper_cond_in),
    .ques_cond_in(ques_cond_in), .dev_cond_in(dev_cond_in), .std_event_in(std_event_in),
    .mav_in(mav_in), .eav_in(eav_in), .acc(acc), .acc_rdata_r(acc_rdata_r),
    .acc_ack_r(acc_ack_r), .acc_err_r(acc_err_r), .stb_r(stb_r),
    .srq_pulse_r(srq_pulse_r), .ist_r(ist_r));
  scsr_ctl_model i_scsr_ctl_model (.clk(clk), .acc(acc), .acc_rdata_r(acc_rdata_r),
    .acc_ack_r(acc_ack_r), .acc_err_r(acc_err_r));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // request pulse lasts one cycle, so count every one of them
  always @(posedge clk) if (srq_pulse_r === 1'b1) n_srq <= n_srq + 1;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic rd_chk(input logic [1:0] g, input logic [2:0] s, input logic [15:0] exp);
    i_scsr_ctl_model.xfer(1'b0, g, s, 16'h0000, rd, er);
    cmp("read data", exp, rd);
    cmp("read refusal", 16'h0000, {15'h0, er});
  endtask : rd_chk
  task automatic wr_chk(input logic [1:0] g, input logic [2:0] s, input logic [15:0] d,
                        input logic e);
    i_scsr_ctl_model.xfer(1'b1, g, s, d, rd, er);
    cmp("write refusal", {15'h0, e}, {15'h0, er});
  endtask : wr_chk
  // pins pass two sync stages before the group sees them
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {oper_cond_in, ques_cond_in, dev_cond_in} = '0;
    {std_event_in, mav_in, eav_in} = '0;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int g = 0; g < 3; g++) begin
      rd_chk(2'(g), `SCSR_SUB_RISE, {1'b0, `SCSR_RISE_RST});
      rd_chk(2'(g), `SCSR_SUB_FALL, {1'b0, `SCSR_FALL_RST});
      rd_chk(2'(g), `SCSR_SUB_MASK, {1'b0, `SCSR_MASK_RST});
      rd_chk(2'(g), `SCSR_SUB_EVENT, 16'h0000);
    end
    wr_chk(2'h1, `SCSR_SUB_RISE, 16'h2a5a, 1'b0);
    wr_chk(2'h1, `SCSR_SUB_FALL, 16'h0f0f, 1'b0);
    wr_chk(2'h1, `SCSR_SUB_MASK, 16'h7001, 1'b0);
    wr_chk(2'h1, `SCSR_SUB_COND, 16'h7fff, 1'b1);
    wr_chk(2'h1, `SCSR_SUB_EVENT, 16'h7fff, 1'b1);
    rd_chk(2'h1, `SCSR_SUB_RISE, 16'h2a5a);
    rd_chk(2'h1, `SCSR_SUB_FALL, 16'h0f0f);
    rd_chk(2'h1, `SCSR_SUB_MASK, 16'h7001);
    rd_chk(2'h1, `SCSR_SUB_MASK, 16'h7001);
    oper_cond_in = 15'h0010;
    ques_cond_in = 15'h0003;
    dev_cond_in = 15'h4000;
    settle;
    rd_chk(2'h0, `SCSR_SUB_COND, 16'h0010);
    rd_chk(2'h0, `SCSR_SUB_COND, 16'h0010);
    rd_chk(2'h1, `SCSR_SUB_COND, 16'h0003);
    rd_chk(2'h2, `SCSR_SUB_COND, 16'h4000);
    rd_chk(2'h0, `SCSR_SUB_EVENT, 16'h0010);
    rd_chk(2'h0, `SCSR_SUB_EVENT, 16'h0000);
    rd_chk(2'h1, `SCSR_SUB_EVENT, 16'h0002);
    rd_chk(2'h2, `SCSR_SUB_EVENT, 16'h4000);
    wr_chk(2'h0, `SCSR_SUB_FALL, 16'h0010, 1'b0);
    oper_cond_in = 15'h0000;
    settle;
    rd_chk(2'h0, `SCSR_SUB_EVENT, 16'h0010);
    wr_chk(2'h3, `SCSR_SUB_SRE, 16'h00c0, 1'b0);
    wr_chk(2'h3, `SCSR_SUB_PPE, 16'h0040, 1'b0);
    {mav_in, eav_in} = 2'h3;
    oper_cond_in = 15'h0010;
    settle;
    srq_base = n_srq;
    wr_chk(2'h0, `SCSR_SUB_MASK, 16'h0010, 1'b0);
    settle;
    cmp("status byte", 16'h00d4, {8'h0, stb_r});
    cmp("service request", 16'h0001, 16'(n_srq - srq_base));
    cmp("poll flag", 16'h0001, {15'h0, ist_r});
    std_event_in = 8'h21;
    @(posedge clk) #1;
    std_event_in = 8'h00;
    wr_chk(2'h3, `SCSR_SUB_ESE, 16'h0001, 1'b0);
    settle;
    cmp("status byte", 16'h00f4, {8'h0, stb_r});
    rd_chk(2'h3, `SCSR_SUB_ESR, 16'h0021);
    rd_chk(2'h3, `SCSR_SUB_ESR, 16'h0000);
    rd_chk(2'h0, `SCSR_SUB_EVENT, 16'h0010);
    settle;
    cmp("status byte", 16'h0014, {8'h0, stb_r});
    cmp("poll flag", 16'h0000, {15'h0, ist_r});
    rd_chk(2'h3, `SCSR_SUB_STB, 16'h0014);
    wr_chk(2'h3, `SCSR_SUB_PPE, 16'h0010, 1'b0);
    settle;
    cmp("poll flag", 16'h0001, {15'h0, ist_r});
    test_done;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
